// File: dtl_pkg.sv
package dtl_pkg;

  // Byte addresses on the register bus
  localparam logic [7:0] DTL_ADR_CTRL = 8'h00;
  localparam logic [7:0] DTL_ADR_RTC_MOD = 8'h04;
  localparam logic [7:0] DTL_ADR_RTC_CNT = 8'h08;
  localparam logic [7:0] DTL_ADR_IRQ_STAT = 8'h0c;
  localparam logic [7:0] DTL_ADR_IRQ_MASK = 8'h10;
  localparam logic [7:0] DTL_ADR_TMR0 = 8'h20;
  localparam logic [7:0] DTL_ADR_TMR1 = 8'h40;
  localparam logic [7:0] DTL_TMR_SPAN = 8'h20;

  // Control register fields
  localparam int DTL_CTRL_RTC_EN = 0;
  localparam int DTL_CTRL_RTC_CLK = 1;
  localparam int DTL_CTRL_FLT_SEL0 = 2;
  localparam int DTL_CTRL_FLT_SEL1 = 3;
  localparam int DTL_CTRL_CONV_LO = 4;
  localparam int DTL_CTRL_WAKE_EN = 6;
  localparam int DTL_CTRL_ADC_SW = 7;
  localparam logic [7:0] DTL_CTRL_RST = 8'h00;
  localparam logic [15:0] DTL_RTC_MOD_RST = 16'hffff;

  // Interrupt status bits
  localparam int DTL_IRQ_W = 6;
  localparam int DTL_IRQ_RTC = 0;
  localparam int DTL_IRQ_T0_OVF = 1;
  localparam int DTL_IRQ_T1_OVF = 2;
  localparam int DTL_IRQ_T0_CH = 3;
  localparam int DTL_IRQ_T1_CH = 4;
  localparam int DTL_IRQ_FLOAT = 5;

  // Conversion trigger select codes
  localparam logic [1:0] DTL_CONV_SW = 2'h0;
  localparam logic [1:0] DTL_CONV_RTC = 2'h1;
  localparam logic [1:0] DTL_CONV_T1C1 = 2'h2;
  localparam logic [1:0] DTL_CONV_CMP = 2'h3;

  // Timer word indices (byte offset / 4 within a timer window)
  localparam logic [2:0] DTL_TW_CTL = 3'h0;
  localparam logic [2:0] DTL_TW_CCTL = 3'h1;
  localparam logic [2:0] DTL_TW_CCR0 = 3'h2;
  localparam logic [2:0] DTL_TW_CNT = 3'h5;
  localparam logic [2:0] DTL_TCTL_RST = 3'h0;
  localparam logic [5:0] DTL_TCCTL_RST = 6'h00;

  typedef enum logic [1:0] {
    DTL_TCLK_SYS = 2'b00,
    DTL_TCLK_AUX = 2'b01,
    DTL_TCLK_SUB = 2'b10,
    DTL_TCLK_INT = 2'b11
  } dtl_tclk_e;

endpackage : dtl_pkg

// File: dtl_timer.sv
`timescale 1ns/1ps
module dtl_timer
  import dtl_pkg::*;
#(
  parameter int W = 16
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic tick_aux,
  input wire logic tick_sub,
  input wire logic tick_int,
  input wire logic wr_en,
  input wire logic [2:0] wr_idx,
  input wire logic [W-1:0] wr_data,
  input wire logic [2:0] rd_idx,
  input wire logic [2:0] cap_a,
  input wire logic [2:0] cap_b,
  output logic [W-1:0] rd_data,
  output logic [2:0] chan_out,
  output logic overflow,
  output logic [2:0] chan_event
);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic [2:0][W-1:0] ccr;
    logic [2:0] ctl;
    logic [5:0] cctl;
    logic [2:0] cap_prev;
    logic [2:0] out;
    logic ovf;
    logic [2:0] ev;
  } dtl_tmr_s;

  dtl_tmr_s s_reg;
  dtl_tmr_s s_next;
  logic tick;
  logic [W-1:0] top;
  logic [2:0] cap_in;

  always_comb begin
    unique case (dtl_tclk_e'(s_reg.ctl[2:1]))
      DTL_TCLK_SYS: tick = 1'b1;
      DTL_TCLK_AUX: tick = tick_aux;
      DTL_TCLK_SUB: tick = tick_sub;
      DTL_TCLK_INT: tick = tick_int;
    endcase
  end

  // Period register of zero means free running over the full range
  assign top = (s_reg.ccr[0] == '0) ? '1 : s_reg.ccr[0];
  assign cap_in = (s_reg.cctl[5:3] & cap_b) | (~s_reg.cctl[5:3] & cap_a);

  always_comb begin
    s_next = s_reg;
    s_next.ovf = 1'b0;
    s_next.ev = 3'h0;
    if (s_reg.ctl[0] && tick) begin
      if (s_reg.cnt == top) begin
        s_next.cnt = '0;
        s_next.ovf = 1'b1;
      end else begin
        s_next.cnt = s_reg.cnt + 1'b1;
      end
    end
    for (int i = 0; i < 3; i++) begin
      if (s_reg.cctl[i]) begin
        if (cap_in[i] && !s_reg.cap_prev[i]) begin
          s_next.ccr[i] = s_reg.cnt;
          s_next.ev[i] = 1'b1;
        end
      end else if (s_reg.ctl[0] && tick && s_reg.cnt == s_reg.ccr[i]) begin
        s_next.ev[i] = 1'b1;
      end
      if (i == 0) begin
        s_next.out[i] = s_reg.out[i] ^ s_next.ovf;
      end else begin
        s_next.out[i] = s_next.cnt < s_reg.ccr[i];
      end
    end
    s_next.cap_prev = cap_in;
    if (wr_en) begin
      unique case (wr_idx)
        DTL_TW_CTL: s_next.ctl = wr_data[2:0];
        DTL_TW_CCTL: s_next.cctl = wr_data[5:0];
        DTL_TW_CNT: s_next.cnt = wr_data;
        3'h2, 3'h3, 3'h4: s_next.ccr[wr_idx - DTL_TW_CCR0] = wr_data;
        default: s_next.ctl = s_reg.ctl;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      s_reg <= '0;
      s_reg.ctl <= DTL_TCTL_RST;
      s_reg.cctl <= DTL_TCCTL_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  always_comb begin
    unique case (rd_idx)
      DTL_TW_CTL: rd_data = W'(s_reg.ctl);
      DTL_TW_CCTL: rd_data = W'(s_reg.cctl);
      DTL_TW_CNT: rd_data = s_reg.cnt;
      3'h2, 3'h3, 3'h4: rd_data = s_reg.ccr[rd_idx - DTL_TW_CCR0];
      default: rd_data = '0;
    endcase
  end

  assign chan_out = s_reg.out;
  assign overflow = s_reg.ovf;
  assign chan_event = s_reg.ev;

endmodule : dtl_timer

// File: dtl_top.sv
// Behaviour
// - Two 16-bit timers, three capture/compare channels each, with PWM and intervals.
// - Second timer clock input and channel 2 alternate capture follow first timer channel 2.
// - Second timer channel 0 alternate capture follows first timer channel 0 output.
// - Second timer channel 1 alternate capture follows first timer channel 1 output.
// - Selected float source firing puts timer output pads into high impedance.
// - Per-timer select: 0 comparator, 1 external pin; floats only its pads.
// - Wake-up counter is 16-bit modulo and counts in every power mode.
// - Wake-up counter overflow can wake the CPU periodically from low-power.
// - In active mode the wake-up counter may run from the subsystem clock.
// - Counter clock mux picks exactly one of auxiliary or subsystem clock.
// - Each counter overflow is an event on first timer channel 0 capture A.
// - Each counter overflow starts a conversion when the trigger field is 01b.
`timescale 1ns/1ps
module dtl_top
  import dtl_pkg::*;
#(
  parameter int W = 16
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic aux_clock,
  input wire logic subsystem_clock,
  input wire logic touch_clock,
  input wire logic touch_capture,
  input wire logic comparator_out,
  input wire logic float_pin0,
  input wire logic float_pin1,
  input wire logic [1:0] t0_pad_in,
  input wire logic [1:0] t1_pad_in,
  input wire logic low_power,
  output logic [1:0] t0_pad_out,
  output logic [1:0] t0_pad_oe,
  output logic [1:0] t1_pad_out,
  output logic [1:0] t1_pad_oe,
  output logic wake_cpu,
  output logic adc_trigger,
  output logic irq
);

  // Asynchronous inputs, all brought through two flops
  localparam int NA = 11;
  localparam int A_AUX = 0;
  localparam int A_SUB = 1;
  localparam int A_TCLK = 2;
  localparam int A_TCAP = 3;
  localparam int A_CMP = 4;
  localparam int A_FP0 = 5;
  localparam int A_FP1 = 6;
  localparam int A_T0P = 7;
  localparam int A_T1P = 9;

  typedef struct packed {
    logic [NA-1:0] s1;
    logic [NA-1:0] s2;
    logic [NA-1:0] s3;
    logic [7:0] ctrl;
    logic [W-1:0] rtc_mod;
    logic [W-1:0] rtc_cnt;
    logic [DTL_IRQ_W-1:0] irq_stat;
    logic [DTL_IRQ_W-1:0] irq_mask;
    logic ack;
    logic [31:0] dat;
    logic [3:0] pad_out;
    logic [3:0] pad_oe;
    logic rtc_ovf;
    logic wake;
    logic adc;
    logic t0c2_prev;
    logic t1c1_prev;
    logic irq;
  } dtl_top_s;

  dtl_top_s s_reg;
  dtl_top_s s_next;

  logic [NA-1:0] async_in;
  logic [NA-1:0] rise;
  logic req;
  logic wr_commit;
  logic [2:0] t_idx;
  logic t0_hit;
  logic t1_hit;
  logic [W-1:0] t0_rd;
  logic [W-1:0] t1_rd;
  logic [2:0] t0_out;
  logic [2:0] t1_out;
  logic t0_ovf;
  logic t1_ovf;
  logic [2:0] t0_ev;
  logic [2:0] t1_ev;
  logic [2:0] t0_cap_a;
  logic [2:0] t0_cap_b;
  logic [2:0] t1_cap_a;
  logic [2:0] t1_cap_b;
  logic t1_int_tick;
  logic rtc_tick;
  logic float0;
  logic float1;
  logic [31:0] rd_mux;
  logic [W-1:0] wdat;

  assign async_in = {t1_pad_in, t0_pad_in, float_pin1, float_pin0, comparator_out,
                     touch_capture, touch_clock, subsystem_clock, aux_clock};

  // Edges are taken from the second and third stages only
  assign rise = s_reg.s2 & ~s_reg.s3;

  assign req = wb_cyc_i && wb_stb_i;
  // Writes land on the edge at which the master sees ack
  assign wr_commit = req && wb_we_i && s_reg.ack;
  assign t_idx = wb_adr_i[4:2];
  assign t0_hit = (wb_adr_i & ~(DTL_TMR_SPAN - 8'h01)) == DTL_ADR_TMR0;
  assign t1_hit = (wb_adr_i & ~(DTL_TMR_SPAN - 8'h01)) == DTL_ADR_TMR1;
  assign wdat = wb_dat_i[W-1:0];

  // First timer inputs
  assign t0_cap_a = {s_reg.s2[A_T0P+1], s_reg.s2[A_T0P], s_reg.rtc_ovf};
  assign t0_cap_b = {s_reg.s2[A_TCAP], s_reg.s2[A_CMP], s_reg.s2[A_AUX]};

  // Second timer alternate capture inputs and internal clock are chained off the first timer's outputs; capture A takes its own pads, channel 0 tied low
  assign t1_cap_a = {s_reg.s2[A_T1P+1], s_reg.s2[A_T1P], 1'b0};
  assign t1_cap_b = {t0_out[2], t0_out[1], t0_out[0]};
  assign t1_int_tick = t0_out[2] && !s_reg.t0c2_prev;

  // Only one wake-up counter source is ever steered through
  always_comb begin
    if (s_reg.ctrl[DTL_CTRL_RTC_CLK] && !low_power) begin
      rtc_tick = rise[A_SUB];
    end else begin
      rtc_tick = rise[A_AUX];
    end
  end

  // Float trigger: 0 picks the comparator, 1 the timer's own pin
  assign float0 = s_reg.ctrl[DTL_CTRL_FLT_SEL0] ? s_reg.s2[A_FP0] : s_reg.s2[A_CMP];
  assign float1 = s_reg.ctrl[DTL_CTRL_FLT_SEL1] ? s_reg.s2[A_FP1] : s_reg.s2[A_CMP];

  dtl_timer #(
    .W(W)
  ) u_tmr0 (
    .sys_clk(sys_clk),
    .reset(reset),
    .tick_aux(rise[A_AUX]),
    .tick_sub(rise[A_SUB]),
    .tick_int(rise[A_TCLK]),
    .wr_en(wr_commit && t0_hit),
    .wr_idx(t_idx),
    .wr_data(wdat),
    .rd_idx(t_idx),
    .cap_a(t0_cap_a),
    .cap_b(t0_cap_b),
    .rd_data(t0_rd),
    .chan_out(t0_out),
    .overflow(t0_ovf),
    .chan_event(t0_ev)
  );

  dtl_timer #(
    .W(W)
  ) u_tmr1 (
    .sys_clk(sys_clk),
    .reset(reset),
    .tick_aux(rise[A_AUX]),
    .tick_sub(rise[A_SUB]),
    .tick_int(t1_int_tick),
    .wr_en(wr_commit && t1_hit),
    .wr_idx(t_idx),
    .wr_data(wdat),
    .rd_idx(t_idx),
    .cap_a(t1_cap_a),
    .cap_b(t1_cap_b),
    .rd_data(t1_rd),
    .chan_out(t1_out),
    .overflow(t1_ovf),
    .chan_event(t1_ev)
  );

  // Unmapped addresses read zero and are still acknowledged
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (t0_hit) begin
      rd_mux = 32'(t0_rd);
    end else if (t1_hit) begin
      rd_mux = 32'(t1_rd);
    end else begin
      unique case (wb_adr_i)
        DTL_ADR_CTRL: rd_mux = 32'({1'b0, s_reg.ctrl[6:0]});
        DTL_ADR_RTC_MOD: rd_mux = 32'(s_reg.rtc_mod);
        DTL_ADR_RTC_CNT: rd_mux = 32'(s_reg.rtc_cnt);
        DTL_ADR_IRQ_STAT: rd_mux = 32'(s_reg.irq_stat);
        DTL_ADR_IRQ_MASK: rd_mux = 32'(s_reg.irq_mask);
        default: rd_mux = 32'h0000_0000;
      endcase
    end
  end

  always_comb begin
    logic [DTL_IRQ_W-1:0] ev;
    logic adc_sw;
    logic [1:0] conv;
    ev = '0;
    adc_sw = 1'b0;
    conv = s_reg.ctrl[DTL_CTRL_CONV_LO+1:DTL_CTRL_CONV_LO];
    s_next = s_reg;
    s_next.s1 = async_in;
    s_next.s2 = s_reg.s1;
    s_next.s3 = s_reg.s2;
    s_next.t0c2_prev = t0_out[2];
    s_next.t1c1_prev = t1_out[1];

    // Bus slave: one ack per request, dropped the cycle after
    s_next.ack = req && !s_reg.ack;
    if (req && !s_reg.ack) begin
      s_next.dat = rd_mux;
    end
    if (wr_commit && wb_sel_i[0]) begin
      unique case (wb_adr_i)
        DTL_ADR_CTRL: begin
          s_next.ctrl = {1'b0, wb_dat_i[6:0]};
          adc_sw = wb_dat_i[DTL_CTRL_ADC_SW];
        end
        DTL_ADR_RTC_MOD: s_next.rtc_mod[7:0] = wb_dat_i[7:0];
        DTL_ADR_IRQ_MASK: s_next.irq_mask = wb_dat_i[DTL_IRQ_W-1:0];
        default: s_next.ctrl = s_reg.ctrl;
      endcase
    end
    if (wr_commit && wb_sel_i[1] && wb_adr_i == DTL_ADR_RTC_MOD) begin
      s_next.rtc_mod[15:8] = wb_dat_i[15:8];
    end

    // Wake-up counter: no gating by power mode, only by its enable
    s_next.rtc_ovf = 1'b0;
    if (s_reg.ctrl[DTL_CTRL_RTC_EN] && rtc_tick) begin
      if (s_reg.rtc_cnt == s_reg.rtc_mod) begin
        s_next.rtc_cnt = '0;
        s_next.rtc_ovf = 1'b1;
      end else begin
        s_next.rtc_cnt = s_reg.rtc_cnt + 1'b1;
      end
    end
    if (!s_reg.ctrl[DTL_CTRL_RTC_EN]) begin
      s_next.rtc_cnt = '0;
    end
    s_next.wake = s_reg.rtc_ovf && s_reg.ctrl[DTL_CTRL_WAKE_EN];

    // Conversion trigger source
    unique case (conv)
      DTL_CONV_SW: s_next.adc = adc_sw;
      DTL_CONV_RTC: s_next.adc = s_reg.rtc_ovf;
      DTL_CONV_T1C1: s_next.adc = t1_out[1] && !s_reg.t1c1_prev;
      DTL_CONV_CMP: s_next.adc = rise[A_CMP];
    endcase

    // Pads: enable drops while the chosen trigger stands
    s_next.pad_out = {t1_out[2:1], t0_out[2:1]};
    s_next.pad_oe = {{2{!float1}}, {2{!float0}}};

    // Sticky status: a new event wins over a write-one clear
    ev[DTL_IRQ_RTC] = s_reg.rtc_ovf;
    ev[DTL_IRQ_T0_OVF] = t0_ovf;
    ev[DTL_IRQ_T1_OVF] = t1_ovf;
    ev[DTL_IRQ_T0_CH] = |t0_ev;
    ev[DTL_IRQ_T1_CH] = |t1_ev;
    ev[DTL_IRQ_FLOAT] = (float0 && s_reg.pad_oe[0]) || (float1 && s_reg.pad_oe[2]);
    if (wr_commit && wb_sel_i[0] && wb_adr_i == DTL_ADR_IRQ_STAT) begin
      s_next.irq_stat = s_reg.irq_stat & ~wb_dat_i[DTL_IRQ_W-1:0];
    end
    s_next.irq_stat = s_next.irq_stat | ev;
    s_next.irq = |(s_next.irq_stat & s_next.irq_mask);
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      s_reg <= '0;
      s_reg.ctrl <= DTL_CTRL_RST;
      s_reg.rtc_mod <= DTL_RTC_MOD_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign wb_dat_o = s_reg.dat;
  assign wb_ack_o = s_reg.ack;
  assign t0_pad_out = s_reg.pad_out[1:0];
  assign t0_pad_oe = s_reg.pad_oe[1:0];
  assign t1_pad_out = s_reg.pad_out[3:2];
  assign t1_pad_oe = s_reg.pad_oe[3:2];
  assign wake_cpu = s_reg.wake;
  assign adc_trigger = s_reg.adc;
  assign irq = s_reg.irq;

endmodule : dtl_top

// File: dtl_assertions.sv
`timescale 1ns/1ps
module dtl_chk
  import dtl_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  input wire logic comparator_out,
  input wire logic float_pin0,
  input wire logic float_pin1,
  input wire logic [1:0] t0_pad_oe,
  input wire logic [1:0] t1_pad_oe,
  input wire logic wake_cpu,
  input wire logic adc_trigger
);
  logic [7:0] ctrl_reg;
  logic f0;
  logic f1;
  // Shadow of the control word, taken at the same edge the block takes it
  assign f0 = ctrl_reg[DTL_CTRL_FLT_SEL0] ? float_pin0 : comparator_out;
  assign f1 = ctrl_reg[DTL_CTRL_FLT_SEL1] ? float_pin1 : comparator_out;
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ctrl_reg <= DTL_CTRL_RST;
    end else if (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0] &&
                 wb_adr_i == DTL_ADR_CTRL) begin
      ctrl_reg <= wb_dat_i[7:0];
    end
  end
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);
  // Five samples leave room for the two-stage synchroniser and the output flop
  property p_float0;
    f0 [*5] |-> t0_pad_oe == 2'b00;
  endproperty
  a_float0: assert property (p_float0) else $error("timer0 pads still driven");
  property p_drive0;
    !f0 [*5] |-> t0_pad_oe == 2'b11;
  endproperty
  a_drive0: assert property (p_drive0) else $error("timer0 pads not driven");
  property p_float1;
    f1 [*5] |-> t1_pad_oe == 2'b00;
  endproperty
  a_float1: assert property (p_float1) else $error("timer1 pads still driven");
  property p_drive1;
    !f1 [*5] |-> t1_pad_oe == 2'b11;
  endproperty
  a_drive1: assert property (p_drive1) else $error("timer1 pads not driven");
  property p_wake_en;
    wake_cpu |-> ctrl_reg[DTL_CTRL_WAKE_EN] || $past(ctrl_reg[DTL_CTRL_WAKE_EN]);
  endproperty
  a_wake_en: assert property (p_wake_en) else $error("wake while disabled");
  property p_wake1;
    wake_cpu |=> !wake_cpu;
  endproperty
  a_wake1: assert property (p_wake1) else $error("wake pulse too long");
  property p_adc;
    wake_cpu && ctrl_reg[5:4] == DTL_CONV_RTC && $past(ctrl_reg[5:4]) == DTL_CONV_RTC
      |-> adc_trigger;
  endproperty
  a_adc: assert property (p_adc) else $error("overflow without conversion");
  property p_ack;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("bus answer late");
  property p_ack1;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack1: assert property (p_ack1) else $error("bus answer too long");
endmodule : dtl_chk

// File: dtl_far.sv
`timescale 1ns/1ps
module dtl_far (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic wake_cpu,
  input wire logic adc_trigger,
  output logic aux_clock,
  output logic subsystem_clock,
  output logic [7:0] n_wake,
  output logic [7:0] n_adc
);
  logic [2:0] div_reg;
  // Aux ticks every 8 cycles, subsystem every 4
  assign aux_clock = div_reg[2];
  assign subsystem_clock = div_reg[1];
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      div_reg <= 3'h0;
      n_wake <= 8'h00;
      n_adc <= 8'h00;
    end else begin
      div_reg <= div_reg + 3'h1;
      n_wake <= n_wake + {7'h00, wake_cpu};
      n_adc <= n_adc + {7'h00, adc_trigger};
    end
  end
endmodule : dtl_far

// File: tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import dtl_pkg::*;
  logic sys_clk = 0;
  logic reset = 1;
  logic cyc = 0, stb = 0, we = 0, cmp = 0, fp0 = 0, fp1 = 0, lp = 0;
  logic [7:0] adr = 0;
  logic [3:0] sel = 0;
  logic [31:0] dat = 0, q, wb_dat_o;
  logic wb_ack_o, aux, sub, wake, adc, irq;
  logic [1:0] oe0, oe1, p0, p1;
  logic [7:0] n_wake, n_adc, w0, a0;
  int errors = 0, checks_done = 0;
  always #2.5 sys_clk = ~sys_clk;
  dtl_top uut (.sys_clk, .reset, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o, .wb_ack_o,
    .aux_clock(aux), .subsystem_clock(sub), .touch_clock(1'b0), .touch_capture(1'b0),
    .comparator_out(cmp), .float_pin0(fp0), .float_pin1(fp1), .t0_pad_in(2'h0),
    .t1_pad_in(2'h0), .low_power(lp), .t0_pad_out(p0), .t0_pad_oe(oe0), .t1_pad_out(p1),
    .t1_pad_oe(oe1), .wake_cpu(wake), .adc_trigger(adc), .irq);
  dtl_far far (.sys_clk, .reset, .wake_cpu(wake), .adc_trigger(adc), .aux_clock(aux),
    .subsystem_clock(sub), .n_wake, .n_adc);
  task automatic print_verdict;
    if (errors == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hf;
    do begin
      @(posedge sys_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (wb_ack_o !== 1'b1) begin
      errors++;
      print_verdict();
    end
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask : wr
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    bus(a, 1'b0, 32'h0);
    chk(q, e);
  endtask : rc
  function automatic logic [7:0] ta(input logic [7:0] b, input logic [2:0] w);
    return b + {3'h0, w, 2'h0};
  endfunction : ta
  // Edge phase against the slow clocks makes the count vary by one
  task automatic win(input logic [7:0] lo, input logic [7:0] hi, input logic adc_on);
    w0 = n_wake;
    a0 = n_adc;
    repeat (256) @(posedge sys_clk);
    w0 = n_wake - w0;
    a0 = n_adc - a0;
    chk(w0 >= lo && w0 <= hi, 1);
    chk(a0, adc_on ? w0 : 8'h00);
  endtask : win
  task automatic flt(input logic [7:0] c, input logic [2:0] src, input logic [3:0] e);
    wr(DTL_ADR_CTRL, {24'h0, c});
    @(posedge sys_clk);
    {cmp, fp1, fp0} <= src;
    repeat (6) @(posedge sys_clk);
    chk({oe1, oe0}, e);
  endtask : flt
  initial begin
    repeat (20) @(posedge sys_clk);
    reset <= 1'b0;
    rc(DTL_ADR_CTRL, {24'h0, DTL_CTRL_RST});
    rc(DTL_ADR_RTC_MOD, {16'h0, DTL_RTC_MOD_RST});
    rc(8'h1c, 32'h0);
    chk({oe1, oe0}, 4'hf);
    chk({p1, p0}, 4'h0);
    wr(ta(DTL_ADR_TMR0, DTL_TW_CCTL), 32'h1);
    wr(ta(DTL_ADR_TMR0, DTL_TW_CTL), 32'h1);
    wr(DTL_ADR_IRQ_MASK, 32'h1);
    wr(DTL_ADR_RTC_MOD, 32'h3);
    wr(DTL_ADR_CTRL, 32'h51);
    win(8'd7, 8'd9, 1'b1);
    bus(DTL_ADR_RTC_CNT, 1'b0, 32'h0);
    chk(q <= 32'h3, 1);
    bus(ta(DTL_ADR_TMR0, DTL_TW_CCR0), 1'b0, 32'h0);
    chk(q != 32'h0, 1);
    chk(irq, 1);
    wr(DTL_ADR_IRQ_MASK, 32'h0);
    repeat (3) @(posedge sys_clk);
    chk(irq, 0);
    wr(DTL_ADR_IRQ_MASK, 32'h1);
    wr(DTL_ADR_CTRL, 32'h53);
    win(8'd15, 8'd17, 1'b1);
    lp <= 1'b1;
    win(8'd7, 8'd9, 1'b1);
    lp <= 1'b0;
    wr(DTL_ADR_CTRL, 32'h43);
    win(8'd15, 8'd17, 1'b0);
    a0 = n_adc;
    wr(DTL_ADR_CTRL, 32'h80);
    repeat (3) @(posedge sys_clk);
    chk(8'(n_adc - a0), 8'h01);
    wr(DTL_ADR_IRQ_STAT, 32'h3f);
    repeat (3) @(posedge sys_clk);
    chk(irq, 0);
    wr(ta(DTL_ADR_TMR0, DTL_TW_CTL), 32'h0);
    wr(ta(DTL_ADR_TMR0, DTL_TW_CNT), 32'h0);
    wr(ta(DTL_ADR_TMR0, DTL_TW_CCTL), 32'h0);
    wr(ta(DTL_ADR_TMR0, DTL_TW_CCR0), 32'h9);
    wr(ta(DTL_ADR_TMR0, 3'h3), 32'h3);
    wr(ta(DTL_ADR_TMR0, 3'h4), 32'h5);
    wr(ta(DTL_ADR_TMR0, DTL_TW_CTL), 32'h1);
    wr(ta(DTL_ADR_TMR1, DTL_TW_CNT), 32'h0);
    wr(ta(DTL_ADR_TMR1, DTL_TW_CTL), 32'h7);
    repeat (200) @(posedge sys_clk);
    bus(ta(DTL_ADR_TMR1, DTL_TW_CNT), 1'b0, 32'h0);
    chk(q >= 32'd18 && q <= 32'd22, 1);
    // One full period of ten counts: ch1 high for 3, ch2 high for 5
    w0 = 8'h00;
    a0 = 8'h00;
    repeat (10) begin
      @(posedge sys_clk);
      w0 = w0 + {7'h00, p0[0]};
      a0 = a0 + {7'h00, p0[1]};
    end
    chk({w0, a0}, {8'd3, 8'd5});
    // A capture replaces the marker with a small count
    for (int i = 0; i < 3; i++) begin
      wr(ta(DTL_ADR_TMR1, DTL_TW_CCR0 + 3'(i)), 32'h1234);
      wr(ta(DTL_ADR_TMR1, DTL_TW_CCTL), 32'((1 << i) | (8 << i)));
      repeat (60) @(posedge sys_clk);
      bus(ta(DTL_ADR_TMR1, DTL_TW_CCR0 + 3'(i)), 1'b0, 32'h0);
      chk(q < 32'h100, 1);
    end
    // Slow clock sources: aux ticks every 8 cycles, subsystem every 4
    wr(ta(DTL_ADR_TMR0, DTL_TW_CCR0), 32'h0);
    for (int k = 1; k < 3; k++) begin
      wr(ta(DTL_ADR_TMR0, DTL_TW_CTL), 32'h0);
      wr(ta(DTL_ADR_TMR0, DTL_TW_CNT), 32'h0);
      wr(ta(DTL_ADR_TMR0, DTL_TW_CTL), 32'((k << 1) | 1));
      repeat (80) @(posedge sys_clk);
      bus(ta(DTL_ADR_TMR0, DTL_TW_CNT), 1'b0, 32'h0);
      chk(q >= 32'(9 * k) && q <= 32'(11 * k), 1);
    end
    flt(8'h00, 3'b100, 4'h0);
    flt(8'h04, 3'b100, 4'h3);
    flt(8'h04, 3'b001, 4'hc);
    flt(8'h08, 3'b010, 4'h3);
    flt(8'h08, 3'b001, 4'hf);
    flt(8'h0c, 3'b011, 4'h0);
    flt(8'h0c, 3'b000, 4'hf);
    // Comparator rising edge as conversion source gives one pulse
    wr(DTL_ADR_CTRL, 32'h30);
    a0 = n_adc;
    cmp <= 1'b1;
    repeat (8) @(posedge sys_clk);
    cmp <= 1'b0;
    chk(8'(n_adc - a0), 8'h01);
    print_verdict();
  end
endmodule : tb_top
bind dtl_top dtl_chk chk_i (.sys_clk, .reset, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
  .wb_sel_i, .wb_dat_i, .wb_ack_o, .comparator_out, .float_pin0, .float_pin1, .t0_pad_oe,
  .t1_pad_oe, .wake_cpu, .adc_trigger);
